//--- design/spms_defines.svh
// Constants for the serial peripheral master/slave core
`ifndef SPMS_DEFINES_SVH
`define SPMS_DEFINES_SVH
// Transmit FIFO shape
`define SPMS_FIFO_W 16
`define SPMS_FIFO_D 16
// SCK edges in one transfer, for the 8-bit and 16-bit widths
`define SPMS_EDGES_8 6'h10
`define SPMS_EDGES_16 6'h20
// Reset value of the receive data register
`define SPMS_WORD_RST 16'h0000
// Width of the configuration snapshot
`define SPMS_CFG_W 14
`endif

//--- design/spms_pkg.sv
// Types shared by the serial peripheral master/slave core
package spms_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_RUN = 2'b10,
    ST_TRAIL = 2'b11
  } spms_state_t;
endpackage

//--- design/spms_core.sv
// Serial peripheral core, master or slave, with its transmit FIFO
//
// Operation
// - Only a core with master select set starts transfers.
// - In master mode a queued word starts a transfer at once.
// - Master SCK rate comes from rate and prescale selects; SCK driven.
// - With fault detect and select output enabled, select output drives low per transfer, high when idle.
// - With fault detect on and select output off, low select input in master mode drops master select, outputs off.
// - A mode fault aborts a running transfer and returns to idle.
// - A mode fault sets the fault flag; interrupt if enabled.
// - Master waits half an SCK period before the first SCK edge.
// - Master configuration change during a transfer aborts it.
// - Slave mode takes SCK as an input from the external master.
// - Data pin roles follow pin control and bidir output enable.
// - Slave select rising forces the slave idle.
// - Deselected slave output floats; selected drives first bit unless the fault flag is set.
// - Deselected slave ignores SCK and does not shift.
// - Phase clear: sample on odd edges, shift on even edges.
// - Phase set: sample on even edges, shift on odd edges after the first, and on the last edge.
// - Phase set: the first edge presents the first output bit.
// - Slave stores the received word and sets the done flag.
// - Slave configuration changes mid-transfer corrupt it; avoided.
// - Data shifts out and in together on the one SCK.
// - Word width is 8 bits, or 16 with width select set.
// - Done flag rises half an SCK period after the last edge as master, on the last edge as slave.

`include "spms_defines.svh"

// ***************************************************************
// Transmit FIFO
// ***************************************************************
module spms_fifo #(
  parameter int WIDTH = `SPMS_FIFO_W,
  parameter int DEPTH = `SPMS_FIFO_D
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } spms_fifo_st_t;

  spms_fifo_st_t st_q;
  spms_fifo_st_t st_d;
  logic push;
  logic pop;

  assign inReady = (st_q.count != (AW+1)'(DEPTH));
  assign outValid = (st_q.count != '0);
  assign outData = st_q.mem[st_q.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wrPtr] = inData;
      st_d.wrPtr = st_q.wrPtr + 1'h1;
    end
    if (pop) begin
      st_d.rdPtr = st_q.rdPtr + 1'h1;
    end
    st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ***************************************************************
// Core
// ***************************************************************
module spms_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Configuration
  input wire logic masterSelectIn,
  input wire logic clockPolarity,
  input wire logic clockPhase,
  input wire logic lsbFirst,
  input wire logic widthSelect,
  input wire logic faultDetectEnable,
  input wire logic selectOutputEnable,
  input wire logic pinControl,
  input wire logic bidirOutputEnable,
  input wire logic irqEnable,
  input wire logic [2:0] rateSel,
  input wire logic [2:0] prescaleSel,
  // Status
  output logic masterSelect,
  output logic transferDoneFlag,
  input wire logic transferDoneClr,
  output logic faultFlag,
  input wire logic faultFlagClr,
  output logic irqReq,
  // Transmit words
  input wire logic txValid,
  output logic txReady,
  input wire logic [15:0] txData,
  // Received word
  output logic [15:0] rxData,
  // Serial clock pin
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOen,
  // Master-out pin
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOen,
  // Master-in pin
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOen,
  // Slave select pin
  input wire logic ssInN,
  output logic ssOutN,
  output logic ssOen
);
  typedef struct packed {
    spms_pkg::spms_state_t state;
    logic masterSel;
    logic msPrev;
    logic [`SPMS_CFG_W-1:0] cfgPrev;
    logic [10:0] div;
    logic [5:0] edgeCnt;
    logic sckLvl;
    logic [15:0] sh;
    logic latched;
    logic outBit;
    logic [15:0] rxData;
    logic doneFlag;
    logic faultFlag;
    logic sckPrev;
    logic ssPrev;
    logic ssOutN;
  } spms_core_st_t;

  spms_core_st_t st_q;
  spms_core_st_t st_d;

  logic fifoValid;
  logic fifoPop;
  logic [15:0] fifoData;
  logic [10:0] halfLen;
  logic [`SPMS_CFG_W-1:0] cfgNow;
  logic [5:0] lastEdge;
  logic tick;
  logic fault;
  logic cfgChg;
  logic dataIn;
  logic edgeEv;
  logic done;
  logic [5:0] k;

  function automatic logic curBit(input logic [15:0] w,
                                  input logic lsb,
                                  input logic wide);
    curBit = lsb ? w[0] : (wide ? w[15] : w[7]);
  endfunction

  function automatic logic [15:0] shiftIn(input logic [15:0] w,
                                          input logic b,
                                          input logic lsb,
                                          input logic wide);
    if (!lsb) begin
      shiftIn = {w[14:0], b};
    end else if (wide) begin
      shiftIn = {b, w[15:1]};
    end else begin
      shiftIn = {w[15:8], b, w[7:1]};
    end
  endfunction

  // Writer stalls through txReady once sixteen words wait
  spms_fifo #(
    .WIDTH(`SPMS_FIFO_W),
    .DEPTH(`SPMS_FIFO_D)
  ) u_txFifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  // ***************************************************************
  // Derived conditions
  // ***************************************************************
  // Half SCK period in module clocks
  assign halfLen = {8'h00, prescaleSel} + 11'h001 << rateSel;
  assign cfgNow = {clockPolarity, clockPhase, selectOutputEnable,
                   lsbFirst, widthSelect, faultDetectEnable, pinControl,
                   bidirOutputEnable & pinControl, prescaleSel, rateSel};
  assign lastEdge = widthSelect ? `SPMS_EDGES_16 : `SPMS_EDGES_8;
  assign tick = (st_q.div == 11'h000);
  assign fault = st_q.masterSel && faultDetectEnable &&
                 !selectOutputEnable && !ssInN;
  assign cfgChg = (cfgNow != st_q.cfgPrev);
  // Input line by role and pin control
  assign dataIn = st_q.masterSel ? (pinControl ? mosiIn : misoIn)
                                 : (pinControl ? misoIn : mosiIn);

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    st_d = st_q;
    fifoPop = 1'h0;
    edgeEv = 1'h0;
    done = 1'h0;
    k = st_q.edgeCnt + 6'h01;
    st_d.msPrev = masterSelectIn;
    st_d.cfgPrev = cfgNow;
    st_d.sckPrev = sckIn;
    st_d.ssPrev = ssInN;
    if (masterSelectIn && !st_q.msPrev) begin
      st_d.masterSel = 1'h1;
    end else if (!masterSelectIn) begin
      st_d.masterSel = 1'h0;
    end
    if (transferDoneClr) begin
      st_d.doneFlag = 1'h0;
    end
    if (faultFlagClr) begin
      st_d.faultFlag = 1'h0;
    end
    if (st_q.masterSel) begin
      if (st_q.state != spms_pkg::ST_IDLE) begin
        st_d.div = tick ? halfLen - 11'h001 : st_q.div - 11'h001;
      end
      case (st_q.state)
        spms_pkg::ST_IDLE: begin
          st_d.sckLvl = 1'h0;
          st_d.edgeCnt = 6'h00;
          st_d.ssOutN = 1'h1;
          // Only the master starts, on a queued word
          // Word moves straight into the shift register
          if (fifoValid && !fault && !cfgChg) begin
            fifoPop = 1'h1;
            st_d.sh = fifoData;
            st_d.outBit = curBit(fifoData, lsbFirst, widthSelect);
            // Half-period lead before the first edge
            st_d.state = spms_pkg::ST_LEAD;
            st_d.div = halfLen - 11'h001;
            st_d.ssOutN = !(faultDetectEnable && selectOutputEnable);
          end
        end
        spms_pkg::ST_LEAD: begin
          if (tick) begin
            edgeEv = 1'h1;
            st_d.state = spms_pkg::ST_RUN;
          end
        end
        spms_pkg::ST_RUN: begin
          edgeEv = tick;
        end
        spms_pkg::ST_TRAIL: begin
          // Done half a period after the last edge
          if (tick) begin
            done = 1'h1;
            st_d.state = spms_pkg::ST_IDLE;
            st_d.ssOutN = 1'h1;
          end
        end
        default: begin
          st_d.state = spms_pkg::ST_IDLE;
        end
      endcase
    end else begin
      // Slave: SCK comes from the external master
      st_d.state = spms_pkg::ST_IDLE;
      st_d.ssOutN = 1'h1;
      st_d.sckLvl = 1'h0;
      if (ssInN) begin
        st_d.edgeCnt = 6'h00;
      end else if (st_q.ssPrev) begin
        // Without a fresh word the last received one goes back out
        if (fifoValid) begin
          fifoPop = 1'h1;
          st_d.sh = fifoData;
        end
        // First bit driven as soon as selected
        st_d.outBit = curBit(st_d.sh, lsbFirst, widthSelect);
      end else begin
        edgeEv = sckIn ^ st_q.sckPrev;
      end
    end

    // One SCK edge moves both directions
    if (edgeEv) begin
      st_d.edgeCnt = k;
      if (st_q.masterSel) begin
        st_d.sckLvl = !st_q.sckLvl;
      end
      if (clockPhase ? !k[0] : k[0]) begin
        st_d.latched = dataIn;
      end
      // Last phase-set edge samples and shifts together
      if (clockPhase && k == lastEdge) begin
        st_d.sh = shiftIn(st_q.sh, dataIn, lsbFirst, widthSelect);
      end else if (clockPhase ? (k[0] && k != 6'h01) : !k[0]) begin
        st_d.sh = shiftIn(st_q.sh, st_q.latched, lsbFirst,
                          widthSelect);
      end
      // Phase set: odd edges present the next bit
      if (clockPhase ? k[0] : !k[0]) begin
        st_d.outBit = curBit(st_d.sh, lsbFirst, widthSelect);
      end
      if (k == lastEdge) begin
        if (st_q.masterSel) begin
          st_d.state = spms_pkg::ST_TRAIL;
        end else begin
          done = 1'h1;
        end
      end
    end

    // Received word to the data register, flag set
    if (done) begin
      st_d.rxData = widthSelect ? st_d.sh : {8'h00, st_d.sh[7:0]};
      st_d.doneFlag = 1'h1;
    end

    // Master configuration change kills the transfer
    if (st_q.masterSel && cfgChg &&
        st_q.state != spms_pkg::ST_IDLE) begin
      st_d.state = spms_pkg::ST_IDLE;
      st_d.ssOutN = 1'h1;
      st_d.sckLvl = 1'h0;
      st_d.edgeCnt = 6'h00;
    end

    // Mode fault: slave, idle, flag set
    if (fault) begin
      st_d.masterSel = 1'h0;
      st_d.faultFlag = 1'h1;
      st_d.state = spms_pkg::ST_IDLE;
      st_d.ssOutN = 1'h1;
      st_d.sckLvl = 1'h0;
      st_d.edgeCnt = 6'h00;
    end
  end

  // Reset to idle slave with flags clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.ssOutN <= 1'h1;
      st_q.rxData <= `SPMS_WORD_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign masterSelect = st_q.masterSel;
  assign transferDoneFlag = st_q.doneFlag;
  assign faultFlag = st_q.faultFlag;
  assign irqReq = irqEnable && (st_q.faultFlag || st_q.doneFlag);
  assign rxData = st_q.rxData;
  // Master drives SCK, polarity only inverts it
  assign sckOut = st_q.sckLvl ^ clockPolarity;
  assign sckOen = !st_q.masterSel;
  // Pin roles; a held fault keeps the slave output off
  assign mosiOut = st_q.outBit;
  assign mosiOen = !(st_q.masterSel &&
                     (!pinControl || bidirOutputEnable));
  assign misoOut = st_q.outBit;
  assign misoOen = !(!st_q.masterSel && !ssInN && !st_q.faultFlag &&
                     (!pinControl || bidirOutputEnable));
  assign ssOutN = st_q.ssOutN;
  assign ssOen = !(st_q.masterSel && faultDetectEnable &&
                   selectOutputEnable);

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_fault_drops_master: assert property (
    fault |=> !st_q.masterSel && sckOen && mosiOen)
    else $error("mode fault left master outputs on");
  a_fault_aborts_idle: assert property (
    fault |=> st_q.state == spms_pkg::ST_IDLE && ssOutN)
    else $error("mode fault did not abort");
  a_fault_sets_flag: assert property (
    fault |=> faultFlag ##0 (irqReq == irqEnable))
    else $error("mode fault flag not set");
  a_lead_half_sck: assert property (
    (st_q.state == spms_pkg::ST_IDLE &&
     st_d.state == spms_pkg::ST_LEAD)
    |=> st_q.div == $past(halfLen) - 11'h001 && sckOut == $past(sckOut))
    else $error("lead delay not half a period");
  a_cfg_abort_idle: assert property (
    (st_q.masterSel && cfgChg && st_q.state != spms_pkg::ST_IDLE)
    |=> st_q.state == spms_pkg::ST_IDLE)
    else $error("config change did not abort");
  a_select_idle_high: assert property (
    (st_q.masterSel && st_q.state == spms_pkg::ST_IDLE) |-> ssOutN)
    else $error("select low while idle");
  a_slave_float_out: assert property (
    (!st_q.masterSel && ssInN) |-> misoOen && sckOen)
    else $error("deselected slave drives");
  a_slave_ignore_sck: assert property (
    (!st_q.masterSel && ssInN) |=> st_q.edgeCnt == 6'h00)
    else $error("deselected slave counted edges");
  a_done_sets_flag: assert property (
    done |=> transferDoneFlag && rxData == $past(st_d.rxData))
    else $error("done flag or data missing");
  a_word_width: assert property (
    done |-> (st_q.edgeCnt + 6'h01) == lastEdge ||
             st_q.state == spms_pkg::ST_TRAIL)
    else $error("transfer length wrong");

  c_master_word: cover property (
    st_q.masterSel && done);
  c_slave_word: cover property (
    !st_q.masterSel && done);
  c_mode_fault: cover property (fault);
  c_cfg_abort: cover property (
    st_q.masterSel && cfgChg && st_q.state == spms_pkg::ST_RUN);
endmodule

//--- tb/spms_slave_model.sv
// Behavioural far-side slave that answers the core in master mode
module spms_slave_model (
  // Select and serial clock
  input wire logic ssN,
  input wire logic sck,
  // Data lines
  input wire logic mosi,
  output logic miso,
  // Format and words
  input wire logic phase,
  input wire logic lsbFirst,
  input wire logic wide,
  input wire logic [15:0] txWord,
  output logic [15:0] rxWord
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  int n;
  int k;
  logic [15:0] sh;

  function automatic logic pick(input int b);
    return lsbFirst ? sh[b] : sh[n-1-b];
  endfunction

  initial begin
    cnt = 0;
    n = 8;
    miso = 1'b0;
    sh = 16'h0000;
    rxWord = 16'h0000;
  end

  // Word is frozen when selected
  always @(negedge ssN) begin
    cnt = 0;
    n = wide ? 16 : 8;
    sh = txWord;
    rxWord = 16'h0000;
    if (!phase) begin
      miso = pick(0);
    end
  end

  // Released line must not keep its last bit
  always @(posedge ssN) begin
    miso = ~miso;
  end

  always @(sck) begin
    if (ssN === 1'b0) begin
      cnt = cnt + 1;
      k = cnt / 2;
      if ((cnt % 2 == 1) != phase) begin
        k = phase ? k - 1 : k;
        if (lsbFirst)
          rxWord[k] = mosi;
        else
          rxWord[n-1-k] = mosi;
      end else if (k < n) begin
        miso = pick(k);
      end
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the serial master/slave core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic pol, ph, lsb, wide;
    logic [2:0] rate, pre;
    logic [15:0] tx, stx;
  } spms_row_t;
  logic sys_clk = 1'b0, srst = 1'b1, mSel = 1'b0;
  logic pol = 1'b0, phase = 1'b0, lsb = 1'b0, wide = 1'b0;
  logic fde = 1'b1, soe = 1'b1, irqEn = 1'b0;
  logic [2:0] rate = 3'h0, pre = 3'h0;
  logic doneClr = 1'b0, faultClr = 1'b0, txValid = 1'b0;
  logic [15:0] txData = 16'h0000, stx = 16'h0000;
  logic tbSck = 1'b0, tbMosi = 1'b0, tbSs = 1'b1;
  logic masterSelect, doneFlag, faultFlag, irqReq, txReady;
  logic [15:0] rxData, modelRx;
  logic sckOut, sckOen, mosiOut, mosiOen, misoOut, misoOen;
  logic ssOutN, ssOen, modelMiso, sckPrev, ssPrev;
  wire logic sckW = sckOen ? tbSck : sckOut;
  wire logic mosiW = mosiOen ? tbMosi : mosiOut;
  wire logic misoW = misoOen ? modelMiso : misoOut;
  wire logic ssW = ssOen ? tbSs : ssOutN;
  int failCount = 0, checksDone = 0, cyc = 0, lastE = 0, edges = 0;
  int gap = 0, lead = 0, ssFall = 0, ssRise = 0, h, r, i, cnt;
  logic [7:0] mi;
  spms_row_t rows [6];

  always #20 sys_clk = ~sys_clk;

  spms_core uut (.sys_clk(sys_clk), .srst(srst), .masterSelectIn(mSel),
    .clockPolarity(pol), .clockPhase(phase), .lsbFirst(lsb),
    .widthSelect(wide), .faultDetectEnable(fde),
    .selectOutputEnable(soe), .pinControl(1'b0),
    .bidirOutputEnable(1'b0), .irqEnable(irqEn), .rateSel(rate),
    .prescaleSel(pre), .masterSelect(masterSelect),
    .transferDoneFlag(doneFlag), .transferDoneClr(doneClr),
    .faultFlag(faultFlag), .faultFlagClr(faultClr), .irqReq(irqReq),
    .txValid(txValid), .txReady(txReady), .txData(txData),
    .rxData(rxData), .sckIn(sckW), .sckOut(sckOut), .sckOen(sckOen),
    .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOen(mosiOen),
    .misoIn(misoW), .misoOut(misoOut), .misoOen(misoOen),
    .ssInN(ssW), .ssOutN(ssOutN), .ssOen(ssOen));

  spms_slave_model slave0 (.ssN(ssW), .sck(sckW), .mosi(mosiW),
    .miso(modelMiso), .phase(phase), .lsbFirst(lsb), .wide(wide),
    .txWord(stx), .rxWord(modelRx));

  // Edge and select monitor on the resolved wires
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (sckW !== sckPrev) begin
      edges = edges + 1;
      gap = cyc - lastE;
      lastE = cyc;
      if (edges == 1)
        lead = cyc - ssFall;
    end
    if (ssPrev === 1'b1 && ssW === 1'b0)
      ssFall = cyc;
    if (ssPrev === 1'b0 && ssW === 1'b1)
      ssRise = ssRise + 1;
    sckPrev = sckW;
    ssPrev = ssW;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task push(input logic [15:0] w);
    txData <= w;
    txValid <= 1'b1;
    @(posedge sys_clk);
    txValid <= 1'b0;
  endtask

  task pulse(input bit fault);
    @(posedge sys_clk);
    if (fault)
      faultClr <= 1'b1;
    else
      doneClr <= 1'b1;
    @(posedge sys_clk);
    faultClr <= 1'b0;
    doneClr <= 1'b0;
  endtask

  task waitDone(input int lim);
    for (int j = 0; j < lim && doneFlag !== 1'b1; j++)
      @(posedge sys_clk);
  endtask

  // Bench plays the external master; 4 clocks per SCK edge
  task slv(input logic ph, input logic [7:0] mo, input int ne,
           output logic [7:0] got);
    int e;
    got = 8'h00;
    tbMosi <= mo[7];
    tbSs <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(misoOen, 1'b0);
    for (e = 1; e <= ne; e++) begin
      @(negedge sys_clk);
      if ((e % 2 == 1) != ph)
        got = {got[6:0], misoW};
      @(posedge sys_clk);
      tbSck <= ~tbSck;
      if (ph ? (e % 2 == 1) : (e % 2 == 0 && e < 16))
        tbMosi <= mo[7 - e / 2];
      repeat (3) @(posedge sys_clk);
    end
    tbSs <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    failCount++;
    final_report();
  end

  initial begin
    rows = '{'{0, 0, 0, 0, 0, 0, 16'h00a5, 16'h003c},
             '{1, 0, 1, 0, 1, 0, 16'h0081, 16'h00e7},
             '{0, 1, 0, 1, 0, 1, 16'hc35a, 16'h1e2d},
             '{1, 1, 1, 1, 2, 0, 16'h8001, 16'h7ffe},
             '{0, 1, 1, 0, 0, 2, 16'h0096, 16'h0069},
             '{1, 0, 0, 1, 1, 1, 16'h0f0f, 16'ha55a}};
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk({masterSelect, doneFlag, faultFlag, rxData, ssOutN, sckOen,
         mosiOen, misoOen}, {3'h0, 16'h0000, 4'hf});
    mSel <= 1'b1;
    // ******************************************************
    // Master transfers, one per row
    // ******************************************************
    for (r = 0; r < 6; r++) begin
      @(posedge sys_clk);
      {pol, phase, lsb, wide} <= {rows[r].pol, rows[r].ph,
                                  rows[r].lsb, rows[r].wide};
      {rate, pre, stx} <= {rows[r].rate, rows[r].pre, rows[r].stx};
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk) edges = 0;
      @(posedge sys_clk);
      push(rows[r].tx);
      waitDone(2000);
      h = (rows[r].pre + 1) << rows[r].rate;
      chk(rxData, rows[r].wide ? rows[r].stx
                  : {8'h00, rows[r].stx[7:0]});
      chk(modelRx, rows[r].wide ? rows[r].tx
                   : {8'h00, rows[r].tx[7:0]});
      chk(edges, rows[r].wide ? 32 : 16);
      chk(gap, h);
      chk(lead >= h - 1 && lead <= h + 1, 1'b1);
      pulse(0);
      $display("master row %0d done", r);
    end
    // ******************************************************
    // Abort on a format change, then mode fault
    // ******************************************************
    {pol, phase, lsb, wide, rate, pre} <= {4'h0, 3'h2, 3'h1};
    repeat (3) @(posedge sys_clk);
    push(16'h00b4);
    repeat (40) @(posedge sys_clk);
    chk(ssOutN, 1'b0);
    lsb <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(ssOutN, 1'b1);
    waitDone(300);
    chk(doneFlag, 1'b0);
    {soe, irqEn} <= 2'b01;
    repeat (3) @(posedge sys_clk);
    push(16'h00d2);
    repeat (40) @(posedge sys_clk);
    tbSs <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({masterSelect, sckOen, mosiOen, misoOen}, 4'h7);
    chk({faultFlag, irqReq}, 2'b11);
    waitDone(300);
    chk(doneFlag, 1'b0);
    tbSs <= 1'b1;
    mSel <= 1'b0;
    pulse(1);
    // Clear lands on the edge that ends the pulse; look one edge later
    @(posedge sys_clk);
    chk(faultFlag, 1'b0);
    $display("abort and fault done");
    // ******************************************************
    // Slave transfers with the bench as master
    // ******************************************************
    {lsb, irqEn} <= 2'b00;
    push(16'h00c3);
    repeat (20) @(posedge sys_clk);
    chk({sckOen, ssOen}, 2'b11);
    chk(misoOen, 1'b1);
    for (i = 0; i < 4; i++) begin
      tbSck <= ~tbSck;
      repeat (4) @(posedge sys_clk);
    end
    chk(doneFlag, 1'b0);
    slv(0, 8'h5a, 6, mi);
    chk(doneFlag, 1'b0);
    push(16'h00c3);
    slv(0, 8'h96, 16, mi);
    chk(rxData, 16'h0096);
    chk(mi, 8'hc3);
    pulse(0);
    phase <= 1'b1;
    push(16'h0071);
    slv(1, 8'h2b, 16, mi);
    chk(rxData, 16'h002b);
    chk(mi, 8'h71);
    $display("slave transfers done");
    // ******************************************************
    // Fill the queue while idle, then drain it as master
    // ******************************************************
    cnt = 0;
    txValid <= 1'b1;
    for (i = 0; i < 20; i++) begin
      txData <= i[15:0];
      @(posedge sys_clk);
      if (txReady === 1'b1)
        cnt++;
    end
    txValid <= 1'b0;
    chk(cnt, 16);
    {phase, soe} <= 2'b01;
    @(posedge sys_clk);
    r = ssRise;
    mSel <= 1'b1;
    for (i = 0; i < 3000 && ssRise - r < 16; i++)
      @(posedge sys_clk);
    chk(ssRise - r, 16);
    chk(modelRx, 16'h000f);
    chk(txReady, 1'b1);
    $display("queue fill and drain done");
    final_report();
  end
endmodule
